/* File: core/gpc_bank.sv */
// AHB-Lite pad configuration register bank for one I/O port
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Atomic-clear ones clear second alternate-function bits
// - Hysteresis bit one selects Schmitt input
// - Slew bit zero fast, one slow
// - Two drive bits form four-level code
// - Serial-bus pins use only lower drive bit
// - Pull select chooses up/down while enabled
// - Slew select ignored on serial-bus pins
// - Pull enabled by OR of both enables
module gpc_bank
    import gpc_pkg::*;
#(
    parameter logic [31:0] BUS_PIN_MASK = 32'h0000_0000  // Pins with two-wire bus function
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] alt_function_select_hi,
    output var gpc_pad_s     pad_ctrl
);

    // ==========================================================================
    // Address phase capture
    logic        wr_pend_r;
    logic [11:0] wr_addr_r;
    logic        take;
    logic [31:0] pull_enable_first_r;
    logic [31:0] pull_enable_second_r;
    logic [31:0] af_hi_r;
    logic [31:0] hyst_r;
    logic [31:0] slew_r;
    logic [31:0] ds0_r;
    logic [31:0] ds1_r;
    logic [31:0] pull_dir_r;
    logic [31:0] rd_nxt;
    logic [31:0] pull_any;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Word offset of a bus address; the two low bits never select a register
    function automatic logic [11:0] word_ofs(input logic [31:0] a);
        word_ofs = a[11:0] & 12'hFFC;
    endfunction : word_ofs

    // Only word transfers are meaningful here; narrower sizes are treated as words
    assign take = hsel && hready && (htrans == GPC_HTRANS_NSQ || htrans == GPC_HTRANS_SEQ);

    // Write is held until its data phase, where hwdata is valid
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end
        else
        begin
            wr_pend_r <= take && hwrite;
            if (take)
                wr_addr_r <= {haddr[11:2], 2'h0};
        end
    end

    // Zero-wait slave: ready from the first edge after reset, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // The bus never stalls once out of reset, and never reports an error
    a_ready_after_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(hresetn) |-> hreadyout)
        else $error("ready low after reset");
    a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        hresp == 1'b0)
        else $error("error response given");

    // ==========================================================================
    // Read/write configuration registers, one process per register so that
    // a fault in one pad concern cannot disturb the others
    // Pull enable, first of the two copies that are ORed
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pull_enable_first_r <= GPC_RST_VALUE;
        else if (wr_pend_r && hit(wr_addr_r, GPC_OFS_PULL_EN_FIRST))
            pull_enable_first_r <= hwdata;
    end

    a_pull_first_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_r && hit(wr_addr_r, GPC_OFS_PULL_EN_FIRST)
        |=> pull_enable_first_r == $past(hwdata))
        else $error("first pull enable write lost");

    // Pull enable, second copy
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pull_enable_second_r <= GPC_RST_VALUE;
        else if (wr_pend_r && hit(wr_addr_r, GPC_OFS_PULL_EN_SECOND))
            pull_enable_second_r <= hwdata;
    end

    a_pull_second_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_r && hit(wr_addr_r, GPC_OFS_PULL_EN_SECOND)
        |=> pull_enable_second_r == $past(hwdata))
        else $error("second pull enable write lost");

    // Input hysteresis enables
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hyst_r <= GPC_RST_VALUE;
        else if (wr_pend_r && hit(wr_addr_r, GPC_OFS_HYST_EN))
            hyst_r <= hwdata;
    end

    a_hyst_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_r && hit(wr_addr_r, GPC_OFS_HYST_EN)
        |=> hyst_r == $past(hwdata))
        else $error("hysteresis write lost");

    // Slew select, one means slow
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            slew_r <= GPC_RST_VALUE;
        else if (wr_pend_r && hit(wr_addr_r, GPC_OFS_SLEW_SEL))
            slew_r <= hwdata;
    end

    a_slew_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_r && hit(wr_addr_r, GPC_OFS_SLEW_SEL)
        |=> slew_r == $past(hwdata))
        else $error("slew write lost");

    // Drive code, lower bit
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ds0_r <= GPC_RST_VALUE;
        else if (wr_pend_r && hit(wr_addr_r, GPC_OFS_DRIVE_LO))
            ds0_r <= hwdata;
    end

    a_drive_lo_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_r && hit(wr_addr_r, GPC_OFS_DRIVE_LO)
        |=> ds0_r == $past(hwdata))
        else $error("drive low write lost");

    // Drive code, upper bit; stored for bus pins too, masked only at the pad
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ds1_r <= GPC_RST_VALUE;
        else if (wr_pend_r && hit(wr_addr_r, GPC_OFS_DRIVE_HI))
            ds1_r <= hwdata;
    end

    a_drive_hi_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_r && hit(wr_addr_r, GPC_OFS_DRIVE_HI)
        |=> ds1_r == $past(hwdata))
        else $error("drive high write lost");

    // Pull direction stored as written; bus pins are software's duty
    // so a wrong setting there reads back exactly as software left it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pull_dir_r <= GPC_RST_VALUE;
        else if (wr_pend_r && hit(wr_addr_r, GPC_OFS_PULL_DIR))
            pull_dir_r <= hwdata;
    end

    a_pull_dir_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_r && hit(wr_addr_r, GPC_OFS_PULL_DIR)
        |=> pull_dir_r == $past(hwdata))
        else $error("pull direction write lost");

    // Second alternate-function select: direct write or atomic clear of ones
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            af_hi_r <= GPC_RST_VALUE;
        else if (wr_pend_r && hit(wr_addr_r, GPC_OFS_AF_HI))
            af_hi_r <= hwdata;
        else if (wr_pend_r && hit(wr_addr_r, GPC_OFS_AF_HI_CLEAR))
            af_hi_r <= af_hi_r & ~hwdata;
    end

    // ==========================================================================
    // Read mux; clear and voltage registers hold nothing and read zero
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        unique case (word_ofs(haddr))
            GPC_OFS_PULL_EN_FIRST:  rd_nxt = pull_enable_first_r;
            GPC_OFS_PULL_EN_SECOND: rd_nxt = pull_enable_second_r;
            GPC_OFS_AF_HI:          rd_nxt = af_hi_r;
            GPC_OFS_AF_HI_CLEAR:    rd_nxt = 32'h0000_0000;
            GPC_OFS_HYST_EN:        rd_nxt = hyst_r;
            GPC_OFS_SLEW_SEL:       rd_nxt = slew_r;
            GPC_OFS_DRIVE_LO:       rd_nxt = ds0_r;
            GPC_OFS_DRIVE_HI:       rd_nxt = ds1_r;
            GPC_OFS_PULL_DIR:       rd_nxt = pull_dir_r;
            GPC_OFS_VOLT_SEL:       rd_nxt = GPC_RST_VALUE;
            default:                rd_nxt = 32'h0000_0000;
        endcase
    end

    // Read data registered so it stands during the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
            hrdata <= rd_nxt;
    end

    // Read data carries the register as it stood when the read was taken
    a_hyst_read: assert property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && word_ofs(haddr) == GPC_OFS_HYST_EN
        |=> hrdata == $past(hyst_r))
        else $error("hysteresis read wrong");
    a_af_read: assert property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && word_ofs(haddr) == GPC_OFS_AF_HI
        |=> hrdata == $past(af_hi_r))
        else $error("alternate select read wrong");

    // ==========================================================================
    // Pad drive, registered so each output is a flip-flop
    // Either pull-enable copy turns the weak resistor on; both pad fields share it
    assign pull_any = pull_enable_first_r | pull_enable_second_r;

    // Pad output registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pad_ctrl               <= '0;
            alt_function_select_hi <= GPC_RST_VALUE;
        end
        else
        begin
            alt_function_select_hi <= af_hi_r;
            pad_ctrl.schmitt_en    <= hyst_r;
            pad_ctrl.slew_slow     <= slew_r & ~BUS_PIN_MASK;
            pad_ctrl.drive_lo      <= ds0_r;
            pad_ctrl.drive_hi      <= ds1_r & ~BUS_PIN_MASK;
            pad_ctrl.pull_en       <= pull_any;
            // Direction is masked by enable so a floating pin shows no pull
            pad_ctrl.pull_up       <= pull_dir_r & pull_any;
        end
    end

    // Outputs follow their registers one cycle later
    a_af_out: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 alt_function_select_hi == $past(af_hi_r))
        else $error("alternate select output wrong");
    a_drive_hi_out: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 pad_ctrl.drive_hi == ($past(ds1_r) & ~BUS_PIN_MASK))
        else $error("drive high bit wrong");
    a_pull_up_out: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 pad_ctrl.pull_up == ($past(pull_dir_r) & $past(pull_any)))
        else $error("pull direction output wrong");

    // ==========================================================================
    // Checks
    a_clear_atomic: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_r && hit(wr_addr_r, GPC_OFS_AF_HI_CLEAR)
        |=> af_hi_r == ($past(af_hi_r) & ~$past(hwdata)))
        else $error("atomic clear wrong");
    a_hyst_out: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 pad_ctrl.schmitt_en == $past(hyst_r))
        else $error("hysteresis output wrong");
    a_slew_out: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 pad_ctrl.slew_slow == ($past(slew_r) & ~BUS_PIN_MASK))
        else $error("slew output wrong");
    a_drive_code: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 pad_ctrl.drive_lo == $past(ds0_r))
        else $error("drive low bit wrong");
    a_bus_drive: assert property (@(posedge hclk) disable iff (!hresetn)
        (pad_ctrl.drive_hi & BUS_PIN_MASK) == 32'h0000_0000)
        else $error("bus pin upper drive used");
    a_pull_dir: assert property (@(posedge hclk) disable iff (!hresetn)
        (pad_ctrl.pull_up & ~pad_ctrl.pull_en) == 32'h0000_0000)
        else $error("pull direction without enable");
    a_bus_slew: assert property (@(posedge hclk) disable iff (!hresetn)
        (pad_ctrl.slew_slow & BUS_PIN_MASK) == 32'h0000_0000)
        else $error("bus pin slew applied");
    a_pull_or: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 pad_ctrl.pull_en == ($past(pull_enable_first_r) | $past(pull_enable_second_r)))
        else $error("pull enable not OR");
    a_clear_read: assert property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && word_ofs(haddr) == GPC_OFS_AF_HI_CLEAR
        |=> hrdata == 32'h0000_0000)
        else $error("clear register read nonzero");
    a_volt_read: assert property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite && word_ofs(haddr) == GPC_OFS_VOLT_SEL
        |=> hrdata == 32'h0000_0000)
        else $error("voltage register read nonzero");

    c_clear_used: cover property (@(posedge hclk) disable iff (!hresetn)
        wr_pend_r && hit(wr_addr_r, GPC_OFS_AF_HI_CLEAR) && (hwdata & af_hi_r) != 32'h0);
    c_pull_up_on: cover property (@(posedge hclk) disable iff (!hresetn)
        pad_ctrl.pull_up != 32'h0);
    c_drive_max: cover property (@(posedge hclk) disable iff (!hresetn)
        (pad_ctrl.drive_lo & pad_ctrl.drive_hi) != 32'h0);
    c_read_back: cover property (@(posedge hclk) disable iff (!hresetn)
        take && !hwrite ##1 hrdata != 32'h0);
    c_word_write: cover property (@(posedge hclk) disable iff (!hresetn)
        take && hwrite && hsize == 3'h2);

endmodule : gpc_bank

`default_nettype wire

/* File: core/gpc_pkg.sv */
// Package for the pad configuration bank: offsets, reset values, pad carrier types
package gpc_pkg;

    // ==========================================================================
    // Register byte offsets
    localparam logic [11:0] GPC_OFS_PULL_EN_FIRST  = 12'h060;
    localparam logic [11:0] GPC_OFS_PULL_EN_SECOND = 12'h064;
    localparam logic [11:0] GPC_OFS_AF_HI          = 12'h074;
    localparam logic [11:0] GPC_OFS_AF_HI_CLEAR    = 12'h07C;
    localparam logic [11:0] GPC_OFS_HYST_EN        = 12'h0A8;
    localparam logic [11:0] GPC_OFS_SLEW_SEL       = 12'h0AC;
    localparam logic [11:0] GPC_OFS_DRIVE_LO       = 12'h0B0;
    localparam logic [11:0] GPC_OFS_DRIVE_HI       = 12'h0B4;
    localparam logic [11:0] GPC_OFS_PULL_DIR       = 12'h0B8;
    localparam logic [11:0] GPC_OFS_VOLT_SEL       = 12'h0C0;

    // ==========================================================================
    // Reset values and bus codes
    localparam logic [31:0] GPC_RST_VALUE  = 32'h0000_0000;
    localparam logic [1:0]  GPC_HTRANS_NSQ = 2'h2;
    localparam logic [1:0]  GPC_HTRANS_SEQ = 2'h3;

    // ==========================================================================
    // Per-pin pad controls as one carrier
    typedef struct packed {
        logic [31:0] schmitt_en;   // 1 = Schmitt receiver
        logic [31:0] slew_slow;    // 1 = slow slew
        logic [31:0] drive_lo;     // Drive code bit 0
        logic [31:0] drive_hi;     // Drive code bit 1
        logic [31:0] pull_en;      // Weak pull resistor on
        logic [31:0] pull_up;      // 1 = pull-up, 0 = pull-down
    } gpc_pad_s;

endpackage : gpc_pkg

/* File: bench/gpio_pad_config_bank_tb.sv */
// Self-checking bench for the pad configuration register bank
`timescale 1ns/10ps
`default_nettype none

module gpio_pad_config_bank_tb;
    import gpc_pkg::*;
    // ==========================================================================
    // Signals and design instance
    localparam logic [31:0] BUS_PINS = 32'h0000_0003; // Pins 0 and 1 carry the serial bus
    logic        hclk      = 1'b0;
    logic        hresetn   = 1'b0;
    logic        hsel      = 1'b0;
    logic [31:0] haddr     = 32'h0000_0000;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0000_0000;
    wire logic   hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] af_hi;
    gpc_pad_s    pad;
    logic [31:0] rd;
    int          n_errors  = 0;
    int          n_tests   = 0;

    // One slave only, so its ready is the bus ready
    assign hready = hreadyout;
    always #2.5 hclk = ~hclk;

    gpc_bank #(.BUS_PIN_MASK(BUS_PINS)) i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .alt_function_select_hi(af_hi), .pad_ctrl(pad));

    // ==========================================================================
    // Reporting and bus tasks
    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    // Bounded wait: a stuck ready must not hang the run
    task wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            n_errors++;
            end_sim();
        end
    endtask : wait_rdy

    task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, a};
        hwrite <= w;
        htrans <= GPC_HTRANS_NSQ;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : bus

    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // Pad outputs lag the registers by one cycle, so allow two edges
    task settle;
        repeat (2) @(posedge hclk);
        #1;
    endtask : settle

    // ==========================================================================
    // Scenarios
    task t_reset;
        logic [11:0] ofs [9];
        ofs = '{GPC_OFS_PULL_EN_FIRST, GPC_OFS_PULL_EN_SECOND, GPC_OFS_AF_HI, GPC_OFS_AF_HI_CLEAR,
                GPC_OFS_HYST_EN, GPC_OFS_SLEW_SEL, GPC_OFS_DRIVE_LO, GPC_OFS_DRIVE_HI,
                GPC_OFS_PULL_DIR};
        // All 32 pins exist here, so no write touches an unimplemented bit
        foreach (ofs[i])
            rdchk(ofs[i], GPC_RST_VALUE);
        chk(pad.schmitt_en | pad.slew_slow | pad.pull_en, GPC_RST_VALUE);
        chk(pad.drive_lo | pad.drive_hi | pad.pull_up | af_hi, GPC_RST_VALUE);
        $display("reset values done");
    endtask : t_reset

    task t_pads;
        bus(1'b1, GPC_OFS_HYST_EN, 32'hA5A5_5A5A);
        bus(1'b1, GPC_OFS_SLEW_SEL, 32'hFFFF_000F);
        bus(1'b1, GPC_OFS_DRIVE_LO, 32'h0F0F_00F3);
        bus(1'b1, GPC_OFS_DRIVE_HI, 32'h3333_CCCF);
        settle();
        chk(pad.schmitt_en, 32'hA5A5_5A5A);
        chk(pad.slew_slow, 32'hFFFF_000C);
        chk(pad.drive_lo, 32'h0F0F_00F3);
        chk(pad.drive_hi, 32'h3333_CCCC);
        rdchk(GPC_OFS_HYST_EN, 32'hA5A5_5A5A);
        // Software never writes the reserved voltage register, it only reads it
        rdchk(GPC_OFS_VOLT_SEL, GPC_RST_VALUE);
        bus(1'b1, 12'h0F0, 32'hFFFF_FFFF);
        rdchk(12'h0F0, 32'h0000_0000);
        $display("pad controls done");
    endtask : t_pads

    task t_pull;
        bus(1'b1, GPC_OFS_PULL_EN_FIRST, 32'h0000_FF00);
        bus(1'b1, GPC_OFS_PULL_EN_SECOND, 32'h00FF_0F00);
        bus(1'b1, GPC_OFS_PULL_DIR, 32'hF0F0_F0F0);
        settle();
        chk(pad.pull_en, 32'h00FF_FF00);
        chk(pad.pull_up, 32'h00F0_F000);
        $display("pull select done");
    endtask : t_pull

    task t_clear;
        bus(1'b1, GPC_OFS_AF_HI, 32'hFFFF_0F0F);
        bus(1'b1, GPC_OFS_AF_HI_CLEAR, 32'h0F0F_00FF);
        rdchk(GPC_OFS_AF_HI, 32'hF0F0_0F00);
        rdchk(GPC_OFS_AF_HI_CLEAR, 32'h0000_0000);
        bus(1'b1, GPC_OFS_AF_HI_CLEAR, 32'h0000_0000);
        rdchk(GPC_OFS_AF_HI, 32'hF0F0_0F00);
        chk(af_hi, 32'hF0F0_0F00);
        $display("atomic clear done");
    endtask : t_clear

    // ==========================================================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_pads();
        t_pull();
        t_clear();
        end_sim();
    end
endmodule : gpio_pad_config_bank_tb

`default_nettype wire
